//--- hdl/svmc_pkg.sv
// Purpose: Shared constants for the supply voltage monitor setup controller
// Assumes: 25 MHz system clock, 8-bit device control registers
// Notes:   Register indices are the controller's view of the device map
package svmc_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS        = 40;
   localparam int CLK_HZ        = 25000000;
   localparam int SETTLE_NS     = 100000;
   localparam int SETTLE_CYC    = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLOW_HZ       = 125000;
   localparam int SLOW_CYC      = (CLK_HZ + SLOW_HZ - 1) / SLOW_HZ;
   localparam int FWAIT_PERIODS = 4;
   localparam int RD_LAT        = 3;
   localparam int TMR_W         = 20;

   // ----------------------------------------------------------------
   // Register indices and fields
   // ----------------------------------------------------------------
   localparam logic [2:0] REG_DET_A = 3'h0;
   localparam logic [2:0] REG_DET_B = 3'h1;
   localparam logic [2:0] REG_MON1  = 3'h2;
   localparam logic [2:0] REG_MON2  = 3'h3;
   localparam logic [2:0] REG_CLK1  = 3'h4;

   localparam int DET2_LVL_BIT = 3;
   localparam int DET1_EN_BIT  = 6;
   localparam int DET2_EN_BIT  = 7;
   localparam int MON_EN_BIT   = 0;
   localparam int MON_FOFF_BIT = 1;
   localparam int MON_FLAG_BIT = 2;
   localparam int MON_DIV_LSB  = 4;
   localparam int MON_MODE_BIT = 6;
   localparam int MON_EDGE_BIT = 7;
   localparam int SLOW_OFF_BIT = 4;

   localparam logic [7:0] DET_B_RST = 8'h00;
   localparam logic [7:0] CLK1_RST  = 8'h10;

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [9:0] {
      S_IDLE   = 10'h001,
      S_DETON  = 10'h002,
      S_SETTLE = 10'h004,
      S_CFG    = 10'h008,
      S_CLRFLG = 10'h010,
      S_OSCON  = 10'h020,
      S_FWAIT  = 10'h040,
      S_ARM    = 10'h080,
      S_RDREQ  = 10'h100,
      S_RDWAIT = 10'h200
   } svmc_state_t;
endpackage

//--- hdl/svmc_timer.sv
// Purpose: Down-counter for the sequencer waits
// Assumes: Load and count share the controller clock enable
// Notes:   Expired is a level while the count rests at zero
`timescale 1ns/100ps
`default_nettype none
module svmc_timer #(
   parameter int W = 20
) (
   input  wire logic         i_clk,    // System clock
   input  wire logic         i_rst_n,  // Sync reset, active low
   input  wire logic         i_ce,     // Clock enable
   input  wire logic         i_load,   // Load the count
   input  wire logic [W-1:0] i_count,  // Cycles to wait
   output logic              o_expired // Count is zero
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_q <= '0;
      end else if (i_ce) begin
         if (i_load) begin
            cnt_q <= i_count;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
         end
      end
   end

   assign o_expired = (cnt_q == '0) && !i_load;
endmodule
`default_nettype wire

//--- hdl/svmc_ctrl.sv
// Purpose: Host sequencer that sets up the device's supply voltage monitors
// Assumes: Device registers take a one-cycle write strobe; read data is async
// Notes:   Shadow copies keep the unrelated bits of shared registers intact
//
// Functional notes
// - Detector enable written 1, then wait settle delay before using it
// - Monitor 2 unfiltered reset mode needs edge select set to 1
// - Monitor 1 unfiltered needs edge select 1 before enabling
// - Filter-off bit 0 filters, 1 bypasses; divider chosen first
// - Stop-mode wake by a monitor needs its filter switched off
// - Same filter-off need holds for monitor 2 wake sources
// - Crossing flag written 0 before the monitor is enabled
// - Filtered use turns slow oscillator on before enabling
// - Filtered use waits four sampling periods before enabling
// - Writing the monitor enable bit is the last setup step
`timescale 1ns/100ps
`default_nettype none
module svmc_ctrl
   import svmc_pkg::*;
#(
   parameter int P_SETTLE_CYC = SETTLE_CYC,
   parameter int P_SLOW_CYC   = SLOW_CYC
) (
   input  wire logic       i_clk,          // System clock, 25 MHz
   input  wire logic       i_rst_n,        // Sync reset, active low
   input  wire logic       i_ce,           // Clock enable, freezes all state
   input  wire logic       i_start,        // Start a monitor setup
   input  wire logic       i_mon2,         // 0 monitor 1, 1 monitor 2
   input  wire logic       i_filter_en,    // Use digital filter
   input  wire logic [1:0] i_div,          // Sample divider, n = 1 << div
   input  wire logic       i_mode_reset,   // Monitor 2: 1 reset, 0 interrupt
   input  wire logic       i_edge,         // Edge select for either monitor when not forced to 1
   input  wire logic       i_stop_wake,    // Monitor wakes from stop mode
   input  wire logic       i_read_level,   // Read detector 2 level
   input  wire logic [7:0] i_reg_rdata,    // Device register read data
   output logic      [2:0] o_reg_addr,     // Device register index
   output logic      [7:0] o_reg_wdata,    // Device register write data
   output logic            o_reg_wr,       // Write strobe
   output logic            o_reg_rd,       // Read strobe
   output logic            o_busy,         // Sequence in progress
   output logic            o_done,         // Setup or read finished
   output logic            o_level,        // Detector 2 level status
   output logic            o_level_valid   // Level read was accepted
);
   // ----------------------------------------------------------------
   // Command latch and helpers
   // ----------------------------------------------------------------
   svmc_state_t      state_q;
   logic             mon2_q, filt_q, mode_q, edge_q, stop_q, det2_ok_q;
   logic [1:0]       div_q;
   logic [7:0]       det_b_q, clk1_q, rd_s1_q, rd_s2_q;
   logic             tmr_ld, tmr_exp;
   logic [TMR_W-1:0] tmr_val, fwait_c;

   function automatic logic [7:0] ctrl_byte(input logic en);
      logic [7:0] b;
      b = 8'h00;
      b[MON_EN_BIT]             = en;
      b[MON_FOFF_BIT]           = !filt_q;
      b[MON_FLAG_BIT]           = 1'b0;
      b[MON_DIV_LSB +: 2]       = div_q;
      b[MON_MODE_BIT]           = mode_q;
      b[MON_EDGE_BIT]           = edge_q;
      return b;
   endfunction

   assign fwait_c = TMR_W'(FWAIT_PERIODS * P_SLOW_CYC) << div_q;
   assign tmr_ld  = (state_q == S_DETON) || (state_q == S_OSCON) || (state_q == S_RDREQ);
   always_comb begin
      if (state_q == S_DETON) begin
         tmr_val = TMR_W'(P_SETTLE_CYC);
      end else if (state_q == S_OSCON) begin
         tmr_val = fwait_c;
      end else begin
         tmr_val = TMR_W'(RD_LAT);
      end
   end

   svmc_timer #(.W(TMR_W)) u_timer (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_ce      (i_ce),
      .i_load    (tmr_ld),
      .i_count   (tmr_val),
      .o_expired (tmr_exp)
   );

   // ----------------------------------------------------------------
   // Read data synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rd_s1_q <= 8'h00;
         rd_s2_q <= 8'h00;
      end else if (i_ce) begin
         rd_s1_q <= i_reg_rdata;
         rd_s2_q <= rd_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_q <= S_IDLE;
         mon2_q <= 1'b0; filt_q <= 1'b0; mode_q <= 1'b0; edge_q <= 1'b0;
         stop_q <= 1'b0; div_q <= 2'h0; det2_ok_q <= 1'b0;
         det_b_q <= DET_B_RST; clk1_q <= CLK1_RST;
         o_reg_addr <= 3'h0; o_reg_wdata <= 8'h00; o_reg_wr <= 1'b0; o_reg_rd <= 1'b0;
         o_busy <= 1'b0; o_done <= 1'b0; o_level <= 1'b0; o_level_valid <= 1'b0;
      end else if (i_ce) begin
         o_reg_wr <= 1'b0;
         o_reg_rd <= 1'b0;
         o_done   <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (i_start) begin
                  mon2_q <= i_mon2;
                  stop_q <= i_stop_wake;
                  filt_q <= i_filter_en && !i_stop_wake;
                  div_q  <= i_div;
                  mode_q <= !i_mon2 || i_mode_reset;
                  // Unfiltered monitor 1 and monitor 2 reset must trip on the fall
                  edge_q <= (!i_filter_en || i_stop_wake) &&
                            (!i_mon2 || i_mode_reset) ? 1'b1 : i_edge;
                  o_busy <= 1'b1;
                  state_q <= S_DETON;
               end else if (i_read_level) begin
                  if (det2_ok_q) begin
                     o_busy  <= 1'b1;
                     state_q <= S_RDREQ;
                  end else begin
                     o_level_valid <= 1'b0;
                     o_done        <= 1'b1;
                  end
               end
            end
            S_DETON: begin
               o_reg_addr  <= REG_DET_B;
               o_reg_wdata <= det_b_q | (mon2_q ? 8'h80 : 8'h40);
               det_b_q     <= det_b_q | (mon2_q ? 8'h80 : 8'h40);
               o_reg_wr    <= 1'b1;
               state_q     <= S_SETTLE;
            end
            S_SETTLE: begin
               if (tmr_exp) begin
                  if (mon2_q) begin
                     det2_ok_q <= 1'b1;
                  end
                  state_q <= S_CFG;
               end
            end
            S_CFG: begin
               o_reg_addr  <= mon2_q ? REG_MON2 : REG_MON1;
               o_reg_wdata <= ctrl_byte(1'b0);
               o_reg_wr    <= 1'b1;
               state_q     <= S_CLRFLG;
            end
            S_CLRFLG: begin
               o_reg_wdata <= ctrl_byte(1'b0);
               o_reg_wr    <= 1'b1;
               state_q     <= filt_q ? S_OSCON : S_ARM;
            end
            S_OSCON: begin
               o_reg_addr  <= REG_CLK1;
               o_reg_wdata <= clk1_q & ~8'h10;
               clk1_q      <= clk1_q & ~8'h10;
               o_reg_wr    <= 1'b1;
               state_q     <= S_FWAIT;
            end
            S_FWAIT: begin
               if (tmr_exp) begin
                  state_q <= S_ARM;
               end
            end
            S_ARM: begin
               o_reg_addr  <= mon2_q ? REG_MON2 : REG_MON1;
               o_reg_wdata <= ctrl_byte(1'b1);
               o_reg_wr    <= 1'b1;
               o_busy      <= 1'b0;
               o_done      <= 1'b1;
               state_q     <= S_IDLE;
            end
            S_RDREQ: begin
               o_reg_addr <= REG_DET_A;
               o_reg_rd   <= 1'b1;
               state_q    <= S_RDWAIT;
            end
            S_RDWAIT: begin
               if (tmr_exp) begin
                  o_level       <= rd_s2_q[DET2_LVL_BIT];
                  o_level_valid <= 1'b1;
                  o_busy        <= 1'b0;
                  o_done        <= 1'b1;
                  state_q       <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Assertion helpers
   // ----------------------------------------------------------------
   logic [TMR_W-1:0] since_q;
   logic             after_det_q, osc_q, flag_clr_q, ctrl_wr;

   assign ctrl_wr = o_reg_wr && ((o_reg_addr == REG_MON1) || (o_reg_addr == REG_MON2));

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         since_q <= '0; after_det_q <= 1'b0; osc_q <= 1'b0; flag_clr_q <= 1'b0;
      end else if (i_ce) begin
         if (o_reg_wr) begin
            since_q <= '0;
         end else if (since_q != '1) begin
            since_q <= since_q + TMR_W'(1);
         end
         if (o_reg_wr) begin
            after_det_q <= (o_reg_addr == REG_DET_B);
         end
         if (o_reg_wr && o_reg_addr == REG_DET_B) begin
            osc_q      <= 1'b0;
            flag_clr_q <= 1'b0;
         end else begin
            if (o_reg_wr && o_reg_addr == REG_CLK1) osc_q <= 1'b1;
            if (ctrl_wr && !o_reg_wdata[MON_EN_BIT]) flag_clr_q <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_settle_wait_done: assert property (
      o_reg_wr && after_det_q |-> since_q >= TMR_W'(P_SETTLE_CYC))
      else $error("detector used before settle delay");
   a_mon1_edge_set: assert property (
      ctrl_wr && o_reg_addr == REG_MON1 && o_reg_wdata[MON_FOFF_BIT]
      |-> o_reg_wdata[MON_EDGE_BIT]) else $error("monitor 1 edge select not 1");
   a_mon2_reset_edge: assert property (
      ctrl_wr && o_reg_addr == REG_MON2 &&
      o_reg_wdata[MON_FOFF_BIT] && o_reg_wdata[MON_MODE_BIT] |-> o_reg_wdata[MON_EDGE_BIT])
      else $error("monitor 2 reset edge select not 1");
   a_stop_filter_off: assert property (
      ctrl_wr && stop_q |-> o_reg_wdata[MON_FOFF_BIT])
      else $error("filter left on for stop wake");
   a_osc_before_arm: assert property (
      ctrl_wr && o_reg_wdata[MON_EN_BIT] &&
      !o_reg_wdata[MON_FOFF_BIT] |-> osc_q) else $error("oscillator off at arm");
   a_filter_wait_min: assert property (
      ctrl_wr && o_reg_wdata[MON_EN_BIT] &&
      !o_reg_wdata[MON_FOFF_BIT] |-> since_q >= fwait_c) else $error("filter wait short");
   a_flag_clear_first: assert property (
      ctrl_wr && o_reg_wdata[MON_EN_BIT] |-> flag_clr_q)
      else $error("crossing flag not cleared");
   // The strobe stands while the clock enable is low, so only a taken arm write counts
   a_arm_last_step: assert property (
      i_ce && ctrl_wr && o_reg_wdata[MON_EN_BIT]
      |-> !o_busy && o_done ##1 !o_reg_wr) else $error("write after arm");
   a_cfg_one_write: assert property (
      ctrl_wr && !o_reg_wdata[MON_EN_BIT] |->
      o_reg_wdata[MON_DIV_LSB +: 2] == div_q && o_reg_wdata[MON_FOFF_BIT] == !filt_q)
      else $error("config write mismatch");
   a_mon1_reset_mode: assert property (
      ctrl_wr && o_reg_addr == REG_MON1
      |-> o_reg_wdata[MON_MODE_BIT]) else $error("monitor 1 not in reset mode");
endmodule
`default_nettype wire

//--- test/svmc_dev_model.sv
// Purpose: Device-side model of the supply monitor control registers
// Assumes: A write is taken at an enabled edge with the strobe high
// Notes:   Counts setup-order faults of the controller in o_viol
`timescale 1ns/100ps
`default_nettype none
module svmc_dev_model
   import svmc_pkg::*;
#(
   parameter int P_SETTLE = 5,
   parameter int P_SLOW   = 2
) (
   input  wire logic       i_clk,       // System clock
   input  wire logic       i_ce,        // Clock enable
   input  wire logic [2:0] i_addr,      // Register index
   input  wire logic [7:0] i_wdata,     // Write data
   input  wire logic       i_wr,        // Write strobe
   input  wire logic       i_supply_hi, // Supply above threshold two
   output logic      [7:0] o_rdata,     // Read data
   output var int          o_viol       // Setup order faults seen
);
   logic [7:0] regs [0:4] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10};
   int         since [0:1] = '{0, 0};
   int         osc_age     = 0;
   logic       sup_q       = 1'b1;
   int         slow_cnt    = 0;
   int         hold_cnt    = 0;
   logic       smp_q       = 1'b1;
   logic       flt_q       = 1'b1;
   logic       lvl_m2;

   // Monitor 2 sees the raw comparator when bypassed, the filtered level otherwise
   assign lvl_m2 = regs[REG_MON2][MON_FOFF_BIT] ? i_supply_hi : flt_q;

   initial o_viol = 0;

   // Level bit stays 0 until detector 2 has settled
   always_comb begin
      o_rdata = regs[i_addr];
      if (i_addr == REG_DET_A)
         o_rdata[DET2_LVL_BIT] = regs[REG_DET_B][DET2_EN_BIT] && since[1] >= P_SETTLE
                                 && i_supply_hi;
   end

   task automatic check_arm(input int d, input logic [7:0] v);
      int fw;
      fw = FWAIT_PERIODS * (1 << v[5:4]) * P_SLOW;
      if (since[d] < P_SETTLE) o_viol++;
      if (v[MON_FLAG_BIT] || regs[REG_MON1 + d][MON_FLAG_BIT]) o_viol++;
      if (regs[REG_MON1 + d][MON_EN_BIT]) o_viol++;
      if (!v[MON_FOFF_BIT] && (regs[REG_CLK1][SLOW_OFF_BIT] || osc_age < fw)) o_viol++;
      if (v[MON_FOFF_BIT] && !v[MON_EDGE_BIT] && (d == 0 || v[MON_MODE_BIT])) o_viol++;
   endtask

   always @(posedge i_clk) begin
      if (i_ce) begin
         for (int d = 0; d < 2; d++)
            since[d] <= regs[REG_DET_B][DET1_EN_BIT + d] ? since[d] + 1 : 0;
         osc_age <= regs[REG_CLK1][SLOW_OFF_BIT] ? 0 : osc_age + 1;
         sup_q   <= lvl_m2;
         // The slow reference never stops, wait mode included, so sampling carries on
         slow_cnt <= (slow_cnt + 1 >= FWAIT_PERIODS * (1 << regs[REG_MON2][MON_DIV_LSB +: 2])
                     * P_SLOW) ? 0 : slow_cnt + 1;
         if (slow_cnt == 0) begin
            smp_q <= i_supply_hi;
            if (smp_q == i_supply_hi)
               flt_q <= i_supply_hi;
         end
         // Supply low stands for both thresholds; the chip stays held until the supply
         // has been good for 32 slow cycles
         if (regs[REG_MON1][MON_EN_BIT] && !i_supply_hi)
            hold_cnt <= 32 * P_SLOW;
         else if (hold_cnt != 0)
            hold_cnt <= hold_cnt - 1;
         // Filtered: both crossings; bypassed: only the selected one
         if (regs[REG_MON2][MON_EN_BIT] && sup_q != lvl_m2 && (!regs[REG_MON2][MON_FOFF_BIT]
             || lvl_m2 != regs[REG_MON2][MON_EDGE_BIT]))
            regs[REG_MON2][MON_FLAG_BIT] <= 1'b1;
         if (i_wr) begin
            if (i_wdata[MON_EN_BIT] && (i_addr == REG_MON1 || i_addr == REG_MON2))
               check_arm(int'(i_addr - REG_MON1), i_wdata);
            regs[i_addr] <= i_wdata;
         end
      end
   end
endmodule
`default_nettype wire

//--- test/tb_svmc_ctrl.sv
// Purpose: Self-checking bench for the monitor setup controller
// Assumes: Device model answers reads combinationally
// Notes:   Clock enable drops at random, stretching the waits it lands in
`timescale 1ns/100ps
`default_nettype none
module tb_svmc_ctrl
   import svmc_pkg::*;
   ;
   localparam int SETTLE = 5;
   localparam int SLOW   = 2;
   logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, start = 1'b0, rd = 1'b0;
   logic        mon2 = 1'b0, filt = 1'b0, mode = 1'b0, edg = 1'b0, wake = 1'b0;
   logic        supply = 1'b1, wr, rdstb, busy, done, lvl, lvl_v, d2_on = 1'b0;
   logic [1:0]  div = 2'h0;
   logic [2:0]  addr, f;
   logic [7:0]  wdata, rdata, detb = 8'h00;
   logic [18:0] e;
   logic [15:0] lf = 16'h32c8;
   logic [18:0] wq [$];
   logic [2:0]  dq [$];
   int          viol, n_errors = 0, cmp_count = 0;

   svmc_ctrl #(.P_SETTLE_CYC(SETTLE), .P_SLOW_CYC(SLOW)) u_dut (
      .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_start(start), .i_mon2(mon2),
      .i_filter_en(filt), .i_div(div), .i_mode_reset(mode), .i_edge(edg),
      .i_stop_wake(wake), .i_read_level(rd), .i_reg_rdata(rdata), .o_reg_addr(addr),
      .o_reg_wdata(wdata), .o_reg_wr(wr), .o_reg_rd(rdstb), .o_busy(busy),
      .o_done(done), .o_level(lvl), .o_level_valid(lvl_v));
   svmc_dev_model #(.P_SETTLE(SETTLE), .P_SLOW(SLOW)) u_dev (
      .i_clk(clk), .i_ce(ce), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_supply_hi(supply), .o_rdata(rdata), .o_viol(viol));

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      if (n_errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial forever #20 clk = ~clk;

   // The state advances by non-blocking update so all readers see one value per edge
   always @(posedge clk) begin
      lf <= lfsr_next(lf);
      ce <= !rst_n || lf[2:0] != 3'h0;
   end

   always @(posedge clk) begin
      if (rst_n && ce) begin
         if (wr) begin
            e = wq.size() ? wq.pop_front() : 19'h7ffff;
            cmp("write index", {5'h00, e[18:16]}, {5'h00, addr});
            cmp("write data", e[7:0] & e[15:8], wdata & e[15:8]);
            cmp("busy at write", {7'h00, wq.size() != 0}, {7'h00, busy});
         end
         if (rdstb)
            cmp("read index", {5'h00, REG_DET_A}, {5'h00, addr});
         if (done) begin
            f = dq.size() ? dq.pop_front() : 3'h7;
            cmp("writes left", 8'h00, 8'(wq.size()));
            cmp("busy at done", 8'h00, {7'h00, busy});
            if (f[2])
               cmp("level", {6'h00, f[1:0]}, {6'h00, lvl_v, lvl & lvl_v});
         end
      end
   end

   task automatic run(input logic st, m2, fe, md, eg, wk, input logic [1:0] dv);
      logic       fo, lx;
      logic [7:0] cfg, msk;
      int         k;
      fo  = !fe || wk;
      cfg = {(fo && (!m2 || md)) ? 1'b1 : eg, m2 ? md : 1'b1, dv, 4'h0 | {fo, 1'b0}};
      msk = {fo || m2, 1'b1, fo ? 2'h0 : 2'h3, 4'h7};
      lx  = lf[5];
      if (st) begin
         detb[m2 ? DET2_EN_BIT : DET1_EN_BIT] = 1'b1;
         wq.push_back({REG_DET_B, 8'hff, detb});
         wq.push_back({REG_MON1 + m2, msk, cfg});
         wq.push_back({REG_MON1 + m2, msk, cfg});
         if (!fo)
            wq.push_back({REG_CLK1, 8'hff, 8'h00});
         wq.push_back({REG_MON1 + m2, msk, cfg | 8'h01});
         dq.push_back(3'h0);
         d2_on = d2_on | m2;
      end else
         dq.push_back({1'b1, d2_on, d2_on & lx});
      mon2 <= m2; filt <= fe; mode <= md; edg <= eg; wake <= wk; div <= dv;
      supply <= st ? supply : lx;
      start <= st;
      rd <= !st || lf[0];
      do @(posedge clk); while (!ce);
      start <= 1'b0;
      rd <= 1'b0;
      if (st) begin
         repeat (3) @(posedge clk);
         start <= 1'b1;
         @(posedge clk);
         start <= 1'b0;
      end
      k = 0;
      while (dq.size() != 0 && k < 3000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 3000)
         cmp("done timeout", 8'h00, 8'h01);
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      run(0, 0, 0, 0, 0, 0, 2'h0);
      run(1, 0, 0, 0, 0, 0, 2'h0);
      run(0, 0, 0, 0, 0, 0, 2'h0);
      run(1, 0, 1, 0, 0, 1, 2'h0);
      for (int d = 0; d < 4; d++)
         run(1, 0, 1, 0, lf[1], 0, d[1:0]);
      run(1, 1, 1, 0, 0, 1, lf[4:3]);
      run(1, 1, 0, 1, 0, 0, lf[4:3]);
      run(1, 1, 0, 0, lf[1], 0, lf[4:3]);
      run(1, 1, 1, 0, lf[1], 0, lf[4:3]);
      run(1, 1, 1, 1, lf[1], 0, lf[4:3]);
      repeat (4) run(0, 0, 0, 0, 0, 0, 2'h0);
      cmp("order faults", 8'h00, viol[7:0]);
      wrap_up();
   end

   // All scenarios need well under 3000 cycles; this margin is generous
   initial begin
      #(40 * 20000);
      n_errors++;
      wrap_up();
   end
endmodule
`default_nettype wire
